// ===== sps_pkg.sv
// Constants, field layouts and state types of the SPI port
package sps_pkg;
	// Register byte addresses
	localparam logic [7:0] SPS_OFF_CTL  = 8'h2c;
	localparam logic [7:0] SPS_OFF_STAT = 8'h30;
	localparam logic [7:0] SPS_OFF_DATA = 8'h34;
	// Control register fields
	localparam int SPS_B_IE  = 7;
	localparam int SPS_B_EN  = 6;
	localparam int SPS_B_LSB = 5;
	localparam int SPS_B_MST = 4;
	localparam int SPS_B_POL = 3;
	localparam int SPS_B_PHA = 2;
	// Status register fields
	localparam int SPS_B_TRANSFER_DONE_FLAG = 7;
	localparam int SPS_B_WRITE_COLLISION_FLAG = 6;
	localparam int SPS_B_DBL  = 0;
	localparam logic [7:0] SPS_CTL_RST = 8'h00;
	// Half serial-clock period minus one, index {double, rate}
	localparam logic [5:0] SPS_HALF [8] = '{6'h01, 6'h07, 6'h1f, 6'h3f,
		6'h00, 6'h03, 6'h0f, 6'h1f};
	localparam logic [3:0] SPS_LAST_EDGE = 4'hf;
	localparam logic [2:0] SPS_LAST_BIT  = 3'h7;

	// One field per serial pin
	typedef struct packed {
		logic mosi;
		logic miso;
		logic sck;
		logic ss;
	} sps_pins_t;

	typedef enum logic [1:0] {
		SPS_OFF = 2'b00,
		SPS_MST = 2'b01,
		SPS_SLV = 2'b10
	} sps_role_t;

	// Whole state of the port
	typedef struct packed {
		logic [7:0] ctl;
		logic       dbl;
		logic       transfer_done_flag;
		logic       write_collision_flag;
		logic       arm_f;
		logic       arm_w;
		logic [7:0] sh;
		logic [7:0] rxb;
		logic       run;
		logic [5:0] hcnt;
		logic [3:0] edg;
		logic [2:0] scnt;
		logic       sck;
		logic       out;
		logic       sck_prev;
		logic       wait_n;
		logic [7:0] rdata;
		logic       irq;
		sps_pins_t  pin;
		sps_pins_t  oe_n;
	} sps_state_t;
endpackage

// ===== sps_sync.sv
// Two-stage synchroniser for the serial pin inputs
`timescale 1ns/10ps
`default_nettype none
module sps_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_i,   // System clock
	input  wire logic         rst_ni,  // Synchronised reset
	input  wire logic [W-1:0] d_i,     // Raw pin levels
	output logic      [W-1:0] q_o      // Synchronised levels
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			meta_q <= '1;
			q_o    <= '1;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== sps_top.sv
// Byte-wide SPI master/slave port with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Slave selected: active; data out driven only if user direction says so.
// - Slave deselected: passive, bit counter and partial byte dropped.
// - Master with select as output: select pin is plain port output.
// - Select driven low in master role: master bit cleared, become slave.
// - Demotion sets done flag; interrupt if enabled globally and locally.
// - Data shifted out and sampled on opposite clock edges.
// - Polarity bit 3 sets the idle level of the serial clock.
// - Phase bit 2 picks sampling on leading or trailing edge.
// - Control register 8 bits, reset zero; nothing runs unless enabled.
// - Bit order one sends LSB first, zero sends MSB first.
// - Interrupt when done flag, local enable and global enable set.
// - Master clock divides system clock by 4, 16, 64 or 128.
// - Rate bits ignored in slave role; clock from outside master.
// - Double speed bit 0 halves divisors to 2, 8, 32, 64.
// - Status bit 7 set when a byte transfer finishes.
// - Done flag cleared by vector ack or status read then data access.
// - Status bit 6 set when data written during a transfer.
// - Status read with collision set then data access clears both.
// - Status bits 5 to 1 read zero.
// - Master: data write starts eight clocks, then stop and flag.
// - Transmit single buffered; received byte held until next completes.
// - Forced inputs per role; remaining pins follow user direction.
module sps_top #(
	parameter int AW = 8
) (
	input  wire logic              clk_i,             // System clock
	input  wire logic              nrst_i,            // Async reset, low
	input  wire logic [AW-1:0]     avm_address_i,     // Byte address
	input  wire logic              avm_read_i,        // Read request
	input  wire logic              avm_write_i,       // Write request
	input  wire logic [31:0]       avm_writedata_i,   // Write data
	input  wire logic [3:0]        avm_byteenable_i,  // Lane enables
	output logic      [31:0]       avm_readdata_o,    // Read data
	output logic                   avm_waitrequest_o, // Stall
	input  wire logic              gie_i,             // Global irq enable
	input  wire logic              irq_ack_i,         // Vector taken
	output logic                   irq_o,             // Interrupt request
	input  wire sps_pkg::sps_pins_t pin_i,            // Pin levels
	input  wire sps_pkg::sps_pins_t port_i,           // Port data bits
	input  wire sps_pkg::sps_pins_t dir_i,            // 1 = output
	output sps_pkg::sps_pins_t     pin_o,             // Pin drive value
	output sps_pkg::sps_pins_t     pin_oe_n_o         // Drive enable, low
);
	import sps_pkg::*;

	sps_state_t q;
	sps_state_t n;
	logic [1:0] rs_q;
	logic       rst_n;
	logic [2:0] syn;
	logic       s_sck;
	logic       s_ss;
	logic       s_mosi;
	logic       req;
	logic       done_acc;
	logic       tick;
	logic       busy;
	logic       start;
	logic       demote;
	logic [5:0] half;
	sps_role_t  role;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rs_q <= 2'b00;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// Slave-side inputs cross through two flops
	sps_sync #(.W(3)) u_sync (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.d_i    ({pin_i.sck, pin_i.ss, pin_i.mosi}),
		.q_o    (syn)
	);
	assign s_sck  = syn[2];
	assign s_ss   = syn[1];
	assign s_mosi = syn[0];

	////////////////////////////////////////////////////////////////////////
	// Bit leaving first, per bit order
	function automatic logic top_bit(input logic [7:0] v, input logic lsb);
		top_bit = lsb ? v[0] : v[7];
	endfunction

	// Shift in one sampled bit from the far end
	function automatic logic [7:0] shift_in(input logic [7:0] v,
		input logic lsb, input logic b);
		shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	// Decoded helpers
	assign req      = avm_read_i | avm_write_i;
	assign done_acc = req & ~q.wait_n;
	assign half     = SPS_HALF[{q.dbl, q.ctl[1:0]}];
	assign tick     = q.hcnt == half;
	assign busy     = q.run | (q.scnt != 3'h0);
	assign start    = done_acc & avm_write_i & avm_byteenable_i[0]
		& (avm_address_i == SPS_OFF_DATA) & ~busy;
	// Another master pulls select low while we drive
	assign demote   = q.ctl[SPS_B_EN] & q.ctl[SPS_B_MST] & ~dir_i.ss
		& ~s_ss;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic       lead;
		logic       samp;
		logic       edge_seen;
		lead      = 1'b0;
		samp      = 1'b0;
		edge_seen = 1'b0;
		n         = q;

		// Bus: first cycle loads read data, second completes
		if (req && q.wait_n) begin
			n.wait_n = 1'b0;
			case (avm_address_i)
				SPS_OFF_CTL:  n.rdata = q.ctl;
				SPS_OFF_STAT: n.rdata = {q.transfer_done_flag, q.write_collision_flag, 5'h00, q.dbl};
				SPS_OFF_DATA: n.rdata = q.rxb;
				default:      n.rdata = 8'h00;
			endcase
		end
		if (done_acc) begin
			n.wait_n = 1'b1;
			// Arming uses the value the master actually read
			if (avm_read_i && avm_address_i == SPS_OFF_STAT) begin
				n.arm_f = q.rdata[SPS_B_TRANSFER_DONE_FLAG];
				n.arm_w = q.rdata[SPS_B_WRITE_COLLISION_FLAG];
			end
			if (avm_address_i == SPS_OFF_DATA) begin
				if (q.arm_f || q.arm_w)
					n.transfer_done_flag = 1'b0;
				if (q.arm_w)
					n.write_collision_flag = 1'b0;
				n.arm_f = 1'b0;
				n.arm_w = 1'b0;
			end
			if (avm_write_i && avm_byteenable_i[0]) begin
				case (avm_address_i)
					SPS_OFF_CTL:  n.ctl = avm_writedata_i[7:0];
					SPS_OFF_STAT: n.dbl = avm_writedata_i[SPS_B_DBL];
					SPS_OFF_DATA: begin
						if (busy)
							n.write_collision_flag = 1'b1;
						else
							n.sh = avm_writedata_i[7:0];
					end
					default: ;
				endcase
			end
		end
		if (irq_ack_i)
			n.transfer_done_flag = 1'b0;

		// Master engine; divider only counts here
		if (start && q.ctl[SPS_B_EN] && q.ctl[SPS_B_MST]) begin
			n.run  = 1'b1;
			n.hcnt = 6'h00;
			n.edg  = 4'h0;
			n.out  = top_bit(avm_writedata_i[7:0], q.ctl[SPS_B_LSB]);
		end else if (q.run) begin
			if (tick) begin
				n.hcnt = 6'h00;
				n.sck  = ~q.sck;
				// Even half edges lead; phase picks sampling edge
				samp = q.edg[0] == q.ctl[SPS_B_PHA];
				if (samp)
					n.sh = shift_in(q.sh, q.ctl[SPS_B_LSB], pin_i.miso);
				else
					n.out = top_bit(q.sh, q.ctl[SPS_B_LSB]);
				n.edg = q.edg + 4'h1;
				if (q.edg == SPS_LAST_EDGE) begin
					n.run  = 1'b0;
					n.rxb  = n.sh;
					n.transfer_done_flag = 1'b1;
				end
			end else begin
				n.hcnt = q.hcnt + 6'h01;
			end
		end else begin
			n.sck = q.ctl[SPS_B_POL];
		end

		// Slave engine on the synchronised clock
		n.sck_prev = s_sck;
		if (q.ctl[SPS_B_EN] && !q.ctl[SPS_B_MST] && !s_ss) begin
			edge_seen = s_sck != q.sck_prev;
			lead      = s_sck != q.ctl[SPS_B_POL];
			samp      = edge_seen && (lead != q.ctl[SPS_B_PHA]);
			if (samp) begin
				n.sh   = shift_in(q.sh, q.ctl[SPS_B_LSB], s_mosi);
				n.scnt = q.scnt + 3'h1;
				if (q.scnt == SPS_LAST_BIT) begin
					n.rxb  = n.sh;
					n.transfer_done_flag = 1'b1;
				end
			end else if (edge_seen || q.scnt == 3'h0) begin
				n.out = top_bit(n.sh, q.ctl[SPS_B_LSB]);
			end
		end else begin
			n.scnt = 3'h0;
		end

		// Forced demotion to slave
		if (demote) begin
			n.ctl[SPS_B_MST] = 1'b0;
			n.transfer_done_flag           = 1'b1;
			n.run            = 1'b0;
		end
		// Disabled port holds no transfer
		if (!q.ctl[SPS_B_EN]) begin
			n.run  = 1'b0;
			n.scnt = 3'h0;
		end

		n.irq = n.transfer_done_flag & n.ctl[SPS_B_IE] & gie_i;

		// Role from the next control value, so pins follow a write at once
		if (!n.ctl[SPS_B_EN])
			role = SPS_OFF;
		else if (n.ctl[SPS_B_MST])
			role = SPS_MST;
		else
			role = SPS_SLV;

		// Pin ownership per role
		n.pin  = port_i;
		n.oe_n = ~dir_i;
		case (role)
			SPS_MST: begin
				n.pin.mosi  = n.out;
				n.pin.sck   = n.sck;
				n.oe_n.miso = 1'b1;
			end
			SPS_SLV: begin
				n.pin.miso  = n.out;
				n.oe_n      = 4'hf;
				n.oe_n.miso = ~(dir_i.miso & ~s_ss);
			end
			SPS_OFF: ;
			default: n.oe_n = 4'hf;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q          <= '0;
			q.ctl      <= SPS_CTL_RST;
			q.wait_n   <= 1'b1;
			q.sck_prev <= 1'b1;
			q.oe_n     <= 4'hf;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from state
	assign avm_readdata_o    = {24'h000000, q.rdata};
	assign avm_waitrequest_o = q.wait_n;
	assign irq_o             = q.irq;
	assign pin_o             = q.pin;
	assign pin_oe_n_o        = q.oe_n;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence s_data_wr;
		done_acc && avm_write_i && avm_byteenable_i[0]
			&& avm_address_i == SPS_OFF_DATA;
	endsequence

	a_irq_gate:
	assert property (q.transfer_done_flag && q.ctl[SPS_B_IE] && gie_i && !irq_ack_i
		&& !done_acc |=> irq_o)
		else $error("irq not raised");
	a_stat_resv:
	assert property (!avm_waitrequest_o && avm_address_i == SPS_OFF_STAT
		&& req |-> avm_readdata_o[5:1] == 5'h00)
		else $error("reserved bits set");
	a_ss_reset:
	assert property (!q.ctl[SPS_B_MST] && s_ss |=> q.scnt == 3'h0)
		else $error("slave count kept");
	a_demote:
	assert property (demote |=> !q.ctl[SPS_B_MST] && q.transfer_done_flag && !q.run)
		else $error("demotion missed");
	a_miso_off:
	assert property (q.ctl[SPS_B_EN] && !q.ctl[SPS_B_MST] && s_ss
		&& !done_acc |=> pin_oe_n_o.miso)
		else $error("miso driven");
	a_idle_pol:
	assert property (!$past(q.run) && !q.run && $stable(q.ctl[SPS_B_POL])
		|-> q.sck == q.ctl[SPS_B_POL])
		else $error("idle level wrong");
	a_sck_rate:
	assert property (q.run && !demote && q.ctl[SPS_B_EN] && !tick
		|=> $stable(q.sck) && q.hcnt == $past(q.hcnt) + 6'h01)
		else $error("divider wrong");
	a_done_flag:
	assert property (q.run && tick && q.edg == SPS_LAST_EDGE
		|=> q.transfer_done_flag && !q.run)
		else $error("done flag missed");
	a_write_collision_flag_set:
	assert property (s_data_wr and busy |=> q.write_collision_flag)
		else $error("collision missed");
	a_off_idle:
	assert property (!q.ctl[SPS_B_EN] ##1 !q.ctl[SPS_B_EN]
		|-> !q.run && q.scnt == 3'h0)
		else $error("disabled port active");
	a_miso_in:
	assert property (q.ctl[SPS_B_EN] && q.ctl[SPS_B_MST] && !demote
		&& !done_acc |=> pin_oe_n_o.miso)
		else $error("miso not input");
	a_slave_in:
	assert property (q.ctl[SPS_B_EN] && !q.ctl[SPS_B_MST] && !done_acc
		|=> pin_oe_n_o.sck && pin_oe_n_o.mosi && pin_oe_n_o.ss)
		else $error("slave pin driven");
endmodule
`default_nettype wire

// ===== sps_slave_model.sv
// Behavioural far-end SPI slave for the master tests
`timescale 1ns/10ps
`default_nettype none
module sps_slave_model (
	input  wire logic       sck_i,  // Clock level
	input  wire logic       mosi_i, // From master
	input  wire logic       ss_ni,  // Select, low
	input  wire logic       clock_polarity_bit_i, // Idle level
	input  wire logic       clock_phase_bit_i, // Trailing sample
	input  wire logic       lsb_i,  // LSB first
	input  wire logic [7:0] tx_i,   // Reply byte
	output logic            miso_o, // To master
	output logic      [7:0] rx_o    // Byte taken
);
	int k = 0;
	int j;
	////////////////////////////////////////////////
	// Sample on one edge, step out on the other; deselect drops the count
	always @(sck_i or posedge ss_ni) begin
		if (ss_ni) begin
			k = 0;
		end else if (((sck_i != clock_polarity_bit_i) ^ clock_phase_bit_i) == 1'b1) begin
			rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
		end else begin
			k = k + 1;
		end
	end
	// Idle line shows the inverse of the last bit, never a stale copy
	always @* begin
		j = k - int'(clock_phase_bit_i);
		if (ss_ni || j < 0 || j > 7)
			miso_o = ~tx_i[lsb_i ? 7 : 0];
		else
			miso_o = tx_i[lsb_i ? j : 7 - j];
	end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench: registers, master table, collision, demotion, slave
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import sps_pkg::*;
	typedef struct packed {
		logic [7:0] ctl;
		logic       dbl;
		logic [7:0] tx;
		logic [7:0] rep;
	} sps_row_t;
	localparam int DV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	localparam sps_row_t ROWS [8] = '{
		'{8'h50, 1'b0, 8'h96, 8'h3c}, '{8'h55, 1'b0, 8'ha1, 8'h5e},
		'{8'h5a, 1'b0, 8'hc3, 8'h81}, '{8'h7f, 1'b0, 8'he7, 8'h18},
		'{8'h7c, 1'b1, 8'h5a, 8'ha5}, '{8'h79, 1'b1, 8'h0f, 8'hf0},
		'{8'h56, 1'b1, 8'h33, 8'hcc}, '{8'h73, 1'b1, 8'h81, 8'h7e}};
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic        rd_r = 1'b0;
	logic        wr_r = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic        irq;
	logic        gie = 1'b0;
	logic        ack = 1'b0;
	sps_pins_t   port = 4'b0001;
	sps_pins_t   dir = 4'b1011;
	sps_pins_t   pin_o;
	sps_pins_t   oe_n;
	sps_pins_t   pin_i;
	logic        s_sck = 1'b0;
	logic        s_mosi = 1'b0;
	logic        s_ss = 1'b1;
	logic        miso_m;
	logic        sck_d = 1'b0;
	logic [7:0]  m_ctl = 8'h00;
	logic [7:0]  m_tx = 8'h00;
	logic [7:0]  m_rx;
	logic [7:0]  q;
	logic [7:0]  srx = 8'h00;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          hc = 0;
	int          hlast = 0;
	////////////////////////////////////////////////
	// Pin levels: whoever drives wins, else the bench
	assign pin_i = {oe_n.mosi ? s_mosi : pin_o.mosi,
		oe_n.miso ? miso_m : pin_o.miso,
		oe_n.sck ? s_sck : pin_o.sck, oe_n.ss ? s_ss : pin_o.ss};
	sps_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .avm_address_i(adr),
		.avm_read_i(rd_r), .avm_write_i(wr_r), .avm_writedata_i(wd),
		.avm_byteenable_i(4'h1), .avm_readdata_o(rdat),
		.avm_waitrequest_o(wreq), .gie_i(gie), .irq_ack_i(ack),
		.irq_o(irq), .pin_i(pin_i), .port_i(port), .dir_i(dir),
		.pin_o(pin_o), .pin_oe_n_o(oe_n));
	sps_slave_model peer (.sck_i(pin_i.sck), .mosi_i(pin_i.mosi),
		.ss_ni(pin_i.ss), .clock_polarity_bit_i(m_ctl[3]), .clock_phase_bit_i(m_ctl[2]),
		.lsb_i(m_ctl[5]), .tx_i(m_tx), .miso_o(miso_m), .rx_o(m_rx));
	// Clock
	always #12.5 clk_i = ~clk_i;
	// Half-period of the serial clock, sampled off the edge
	always @(negedge clk_i) begin
		sck_d <= pin_i.sck;
		hc <= (pin_i.sck != sck_d) ? 1 : hc + 1;
		if (pin_i.sck != sck_d) hlast <= hc;
	end
	// Hang guard, well above the longest run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		adr <= a;
		wd <= {24'h0, d};
		wr_r <= w;
		rd_r <= ~w;
		// Request stands until waitrequest is seen low at a rising edge
		do @(posedge clk_i); while (wreq !== 1'b0);
		q = rdat[7:0];
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task automatic poll();
		do bus(1'b0, SPS_OFF_STAT, 8'h00); while (q[7] !== 1'b1);
	endtask
	// Bench as outside master, mode 0, half period four cycles
	task automatic sbyte(input logic [7:0] v, input int n);
		int b;
		for (b = 7; b >= 8 - n; b--) begin
			s_mosi <= v[b];
			repeat (4) @(posedge clk_i);
			srx = {srx[6:0], pin_i.miso};
			s_sck <= 1'b1;
			repeat (4) @(posedge clk_i);
			s_sck <= 1'b0;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(SPS_OFF_CTL, 8'h00);
		rd(SPS_OFF_STAT, 8'h00);
		rd(8'h40, 8'h00);
		chk({4'h0, oe_n}, {4'h0, ~dir});
		chk({4'h0, pin_o}, {4'h0, port});
		foreach (ROWS[i]) begin
			m_ctl <= ROWS[i].ctl;
			m_tx <= ROWS[i].rep;
			bus(1'b1, SPS_OFF_CTL, ROWS[i].ctl);
			bus(1'b1, SPS_OFF_STAT, {7'h0, ROWS[i].dbl});
			chk({7'h0, pin_i.sck}, {7'h0, ROWS[i].ctl[3]});
			port <= 4'b0000;
			bus(1'b1, SPS_OFF_DATA, ROWS[i].tx);
			poll();
			rd(SPS_OFF_DATA, ROWS[i].rep);
			chk(m_rx, ROWS[i].tx);
			chk(8'(hlast), 8'(DV[{ROWS[i].dbl, ROWS[i].ctl[1:0]}] / 2));
			rd(SPS_OFF_STAT, {7'h0, ROWS[i].dbl});
			port <= 4'b0001;
		end
		// Second data write while a byte is shifting
		m_ctl <= 8'h51;
		bus(1'b1, SPS_OFF_CTL, 8'h51);
		bus(1'b1, SPS_OFF_STAT, 8'h00);
		port <= 4'b0000;
		bus(1'b1, SPS_OFF_DATA, 8'h11);
		bus(1'b1, SPS_OFF_DATA, 8'h22);
		poll();
		chk(q, 8'hc0);
		chk(m_rx, 8'h11);
		bus(1'b0, SPS_OFF_DATA, 8'h00);
		rd(SPS_OFF_STAT, 8'h00);
		port <= 4'b0001;
		// Select high and settled before it turns into an input
		repeat (4) @(posedge clk_i);
		dir <= 4'b1010;
		bus(1'b1, SPS_OFF_CTL, 8'hd0);
		rd(SPS_OFF_CTL, 8'hd0);
		// Another master pulls select low
		s_ss <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd(SPS_OFF_CTL, 8'hc0);
		chk({6'h0, oe_n.mosi, oe_n.sck}, 8'h03);
		chk({7'h0, irq}, 8'h00);
		gie <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq}, 8'h01);
		ack <= 1'b1;
		@(posedge clk_i);
		ack <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq}, 8'h00);
		rd(SPS_OFF_STAT, 8'h00);
		// Software sets the master bit again once select is released
		s_ss <= 1'b1;
		repeat (4) @(posedge clk_i);
		bus(1'b1, SPS_OFF_CTL, 8'h50);
		rd(SPS_OFF_CTL, 8'h50);
		// Slave role with partial byte, then a whole one
		gie <= 1'b0;
		s_ss <= 1'b1;
		dir <= 4'b0100;
		bus(1'b1, SPS_OFF_CTL, 8'h43);
		chk({7'h0, oe_n.miso}, 8'h01);
		s_ss <= 1'b0;
		sbyte(8'hff, 3);
		s_ss <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({7'h0, oe_n.miso}, 8'h01);
		bus(1'b1, SPS_OFF_DATA, 8'ha5);
		s_ss <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({7'h0, oe_n.miso}, 8'h00);
		sbyte(8'h3c, 8);
		repeat (8) @(posedge clk_i);
		rd(SPS_OFF_STAT, 8'h80);
		rd(SPS_OFF_DATA, 8'h3c);
		chk(srx, 8'ha5);
		give_verdict();
	end
endmodule
`default_nettype wire
